// File: rtl/dfcc_pkg.sv
// Constants and types for the configuration control block of the dual FIR.
// Assumes one filter clock and a strobed write-only configuration port.
`default_nettype none
package dfcc_pkg;
    // Port widths
    localparam int DATA_W = 10;
    localparam int ADDR_W = 9;
    localparam int COEF_ADDR_W = 8;
    localparam int DEC_W = 4;
    localparam int RPOS_W = 4;
    localparam int NUM_CELLS = 2;
    localparam int ROUND_POSITIONS = 12;

    // Register map
    localparam logic [ADDR_W-1:0] ADDR_STRUCT_CTRL = 9'h000;
    localparam logic [ADDR_W-1:0] ADDR_FORMAT_CTRL = 9'h001;
    localparam int ADDR_COEF_BIT = 8;
    localparam logic [DATA_W-1:0] STRUCT_CTRL_RESET = 10'h000;
    localparam logic [DATA_W-1:0] FORMAT_CTRL_RESET = 10'h000;

    // Structure control fields
    localparam int DEC_LSB = 0;
    localparam int MODE_BIT = 4;
    localparam int SYMM_BIT = 5;
    localparam int PARITY_A_BIT = 6;
    localparam int PARITY_B_BIT = 7;
    localparam int B_SRC_BIT = 8;

    // Format and rounding control fields
    localparam int FMT_A_DATA_BIT = 0;
    localparam int FMT_A_COEF_BIT = 1;
    localparam int FMT_B_DATA_BIT = 2;
    localparam int FMT_B_COEF_BIT = 3;
    localparam int REV_DIS_BIT = 4;
    localparam int RPOS_LSB = 5;
    localparam int ROUND_DIS_BIT = 9;

    // Timing in filter clocks and sequencer counter width
    localparam int RESET_CYCLES = 6;
    localparam int PIPE_LATENCY = 8;
    localparam int BLOCK_TRANSFER_STROBE_DELAY_EVEN = 3;
    localparam int BLOCK_TRANSFER_STROBE_DELAY_ODD = 4;
    localparam int CNT_W = 4;

    typedef struct packed {
        logic [DEC_W-1:0] dec_factor;
        logic dual_mode;
        logic odd_symmetry;
        logic [NUM_CELLS-1:0] even_taps;
        logic b_from_b_bus;
    } dfcc_struct_t;

    typedef struct packed {
        logic [NUM_CELLS-1:0] data_twos;
        logic [NUM_CELLS-1:0] coef_twos;
        logic reversal_enable;
        logic [RPOS_W-1:0] round_pos;
        logic round_enable;
    } dfcc_format_t;

    typedef struct packed {
        logic [COEF_ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } dfcc_coef_wr_t;

    typedef enum {
        DFCC_RUN,
        DFCC_RESET,
        DFCC_FILL
    } dfcc_state_t;
endpackage
`default_nettype wire

// File: rtl/dfcc_config_control.sv
// Configuration control of the dual FIR: two write-only control words,
// the coefficient write hand-off and the write-triggered filter reset.
// Assumes the write strobe is its own clock and all filter pins are synchronous to core_clk.
`default_nettype none
module dfcc_config_control
    import dfcc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Configuration port
    input wire logic [DATA_W-1:0] config_data_bus,
    input wire logic [ADDR_W-1:0] config_addr_bus,
    input wire logic config_wr_n,
    // Filter control pins
    input wire logic block_transfer_strobe,
    input wire logic forward_path_enable_n,
    input wire logic reverse_path_enable_n,
    input wire logic sample_shift_enable_n,
    input wire logic accumulate_enable,
    input wire logic [1:0] output_combine_select,
    // Coefficient storage hand-off
    output dfcc_coef_wr_t coef_wr,
    output logic coef_wr_toggle,
    // Decoded configuration
    output dfcc_struct_t struct_cfg,
    output dfcc_format_t format_cfg,
    output logic [DEC_W:0] tap_delay,
    output logic [ROUND_POSITIONS-1:0] round_select,
    // Per-cell and shared filter control
    output logic [NUM_CELLS-1:0] cell_transfer_n,
    output logic [NUM_CELLS-1:0] cell_alu_subtract,
    output logic [NUM_CELLS-1:0] cell_fwd_zero,
    output logic [NUM_CELLS-1:0] cell_rev_zero,
    output logic cell_b_from_b_bus,
    output logic shift_enable,
    output logic accumulate,
    output logic [1:0] combine_select,
    // Status
    output logic filter_reset,
    output logic pipeline_primed
);
    // Write-strobe domain
    logic [DATA_W-1:0] struct_word;
    logic [DATA_W-1:0] format_word;
    logic ctrl_toggle;
    logic coef_toggle;
    logic is_coef;
    logic is_struct;
    logic is_format;

    // Filter clock domain
    logic [2:0] ctrl_sync;
    logic ctrl_seen;
    logic ctrl_event;
    dfcc_state_t state;
    dfcc_state_t next_state;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic block_transfer_strobe_in_n;
    logic fwd_in_n;
    logic rev_in_n;
    logic shift_in_n;
    logic acc_in;
    logic [1:0] mux_in;
    logic [BLOCK_TRANSFER_STROBE_DELAY_ODD-1:0] block_transfer_strobe_line;
    logic [ROUND_POSITIONS-1:0] next_round_select;

    assign is_coef = config_addr_bus[ADDR_COEF_BIT];
    assign is_struct = config_addr_bus == ADDR_STRUCT_CTRL;
    assign is_format = config_addr_bus == ADDR_FORMAT_CTRL;

    // Control words are clocked by the strobe so loading needs no filter clock
    always_ff @(posedge config_wr_n or negedge rst_n) begin
        if (!rst_n) begin
            struct_word <= STRUCT_CTRL_RESET;
            format_word <= FORMAT_CTRL_RESET;
            ctrl_toggle <= 1'b0;
        end else if (is_struct) begin
            struct_word <= config_data_bus;
            ctrl_toggle <= ~ctrl_toggle;
        end else if (is_format) begin
            format_word <= config_data_bus;
            ctrl_toggle <= ~ctrl_toggle;
        end
    end

    // Coefficient writes pass on with their own event; reserved addresses are dropped
    always_ff @(posedge config_wr_n or negedge rst_n) begin
        if (!rst_n) begin
            coef_wr <= '0;
            coef_toggle <= 1'b0;
        end else if (is_coef) begin
            coef_wr.addr <= config_addr_bus[COEF_ADDR_W-1:0];
            coef_wr.data <= config_data_bus;
            coef_toggle <= ~coef_toggle;
        end
    end

    assign coef_wr_toggle = coef_toggle;

    // Write event crossing: counts once second and third stages agree
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_sync <= 3'h0;
        end else begin
            ctrl_sync <= {ctrl_sync[1:0], ctrl_toggle};
        end
    end

    assign ctrl_event = (ctrl_sync[1] == ctrl_sync[2]) && (ctrl_sync[2] != ctrl_seen);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_seen <= 1'b0;
        end else if (ctrl_event) begin
            ctrl_seen <= ctrl_sync[2];
        end
    end

    // Shadow copies; words are settled by the time the event arrives
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            struct_cfg <= '0;
            format_cfg <= '0;
        end else if (ctrl_event) begin
            struct_cfg.dec_factor <= struct_word[DEC_LSB +: DEC_W];
            struct_cfg.dual_mode <= struct_word[MODE_BIT];
            struct_cfg.odd_symmetry <= struct_word[SYMM_BIT];
            struct_cfg.even_taps <= {struct_word[PARITY_B_BIT], struct_word[PARITY_A_BIT]};
            struct_cfg.b_from_b_bus <= struct_word[B_SRC_BIT];
            format_cfg.data_twos <= {format_word[FMT_B_DATA_BIT], format_word[FMT_A_DATA_BIT]};
            format_cfg.coef_twos <= {format_word[FMT_B_COEF_BIT], format_word[FMT_A_COEF_BIT]};
            format_cfg.reversal_enable <= ~format_word[REV_DIS_BIT];
            format_cfg.round_pos <= format_word[RPOS_LSB +: RPOS_W];
            format_cfg.round_enable <= ~format_word[ROUND_DIS_BIT];
        end
    end

    // One-hot rounding weight, none when disabled or position out of range
    always_comb begin
        next_round_select = '0;
        if (!format_word[ROUND_DIS_BIT] && (format_word[RPOS_LSB +: RPOS_W] < 4'(ROUND_POSITIONS))) begin
            next_round_select[format_word[RPOS_LSB +: RPOS_W]] = 1'b1;
        end
    end

    // Decoded values registered together with the shadow copies
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tap_delay <= 5'h01;
            round_select <= '0;
        end else if (ctrl_event) begin
            tap_delay <= {1'b0, struct_word[DEC_LSB +: DEC_W]} + 5'h01;
            round_select <= next_round_select;
        end
    end

    // Reset sequencer; a new write restarts the count
    always_comb begin
        next_state = state;
        next_count = count;
        case (state)
            DFCC_RUN: begin
                next_count = '0;
            end
            DFCC_RESET: begin
                if (count == 4'(RESET_CYCLES - 1)) begin
                    next_state = DFCC_FILL;
                    next_count = '0;
                end else begin
                    next_count = count + 4'h1;
                end
            end
            DFCC_FILL: begin
                if (count == 4'(PIPE_LATENCY - 1)) begin
                    next_state = DFCC_RUN;
                    next_count = '0;
                end else if (!shift_in_n) begin
                    next_count = count + 4'h1;
                end
            end
            default: begin
                next_state = DFCC_RUN;
                next_count = '0;
            end
        endcase
        if (ctrl_event) begin
            next_state = DFCC_RESET;
            next_count = '0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= DFCC_RUN;
            count <= '0;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    // Only filter logic is reset; coefficient hand-off is untouched
    assign filter_reset = (state == DFCC_RESET);
    assign pipeline_primed = (state == DFCC_RUN);

    // Filter control pins registered on the clock edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            block_transfer_strobe_in_n <= 1'b1;
            fwd_in_n <= 1'b1;
            rev_in_n <= 1'b1;
            shift_in_n <= 1'b1;
            acc_in <= 1'b0;
            mux_in <= 2'h0;
        end else begin
            block_transfer_strobe_in_n <= block_transfer_strobe;
            fwd_in_n <= forward_path_enable_n;
            rev_in_n <= reverse_path_enable_n;
            shift_in_n <= sample_shift_enable_n;
            acc_in <= accumulate_enable;
            mux_in <= output_combine_select;
        end
    end

    // Transfer strobe delay line, flushed by the write-triggered reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            block_transfer_strobe_line <= '1;
        end else if (filter_reset) begin
            block_transfer_strobe_line <= '1;
        end else begin
            block_transfer_strobe_line <= {block_transfer_strobe_line[BLOCK_TRANSFER_STROBE_DELAY_ODD-2:0], block_transfer_strobe_in_n};
        end
    end

    genvar c;
    generate
        for (c = 0; c < NUM_CELLS; c++) begin : g_cell
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    cell_transfer_n[c] <= 1'b1;
                    cell_alu_subtract[c] <= 1'b0;
                    cell_fwd_zero[c] <= 1'b1;
                    cell_rev_zero[c] <= 1'b1;
                end else if (filter_reset) begin
                    cell_transfer_n[c] <= 1'b1;
                    cell_alu_subtract[c] <= struct_cfg.odd_symmetry;
                    cell_fwd_zero[c] <= 1'b1;
                    cell_rev_zero[c] <= 1'b1;
                end else begin
                    // Even taps tap one stage earlier
                    cell_transfer_n[c] <= struct_cfg.even_taps[c] ?
                        block_transfer_strobe_line[BLOCK_TRANSFER_STROBE_DELAY_EVEN-2] : block_transfer_strobe_line[BLOCK_TRANSFER_STROBE_DELAY_ODD-2];
                    cell_alu_subtract[c] <= struct_cfg.odd_symmetry;
                    cell_fwd_zero[c] <= fwd_in_n;
                    cell_rev_zero[c] <= rev_in_n;
                end
            end
        end
    endgenerate

    // Cell B source only matters in dual mode; single mode cascades from cell A
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cell_b_from_b_bus <= 1'b0;
            shift_enable <= 1'b0;
            accumulate <= 1'b0;
            combine_select <= 2'h0;
        end else begin
            cell_b_from_b_bus <= struct_cfg.dual_mode & struct_cfg.b_from_b_bus;
            shift_enable <= ~shift_in_n & ~filter_reset;
            accumulate <= acc_in & ~filter_reset;
            combine_select <= mux_in;
        end
    end
endmodule
`default_nettype wire

// File: sim/dfcc_host_model.sv
// Host model: strobed writes on the configuration port.
// Assumes the bench calls write() and waits for its return.
`default_nettype none
module dfcc_host_model
    import dfcc_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Configuration port
    output logic [DATA_W-1:0] config_data_bus,
    output logic [ADDR_W-1:0] config_addr_bus,
    output logic config_wr_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        config_data_bus = '0;
        config_addr_bus = '0;
        config_wr_n = 1'b1;
    end
    // One strobed write; writes to addresses 9'h002 to 9'h011 are skipped
    task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        if (a inside {[9'h002:9'h011]}) begin
            return;
        end
        @(posedge core_clk);
        config_addr_bus <= a;
        config_data_bus <= (a == ADDR_STRUCT_CTRL) ? {1'b0, d[8:0]} : d;
        config_wr_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        config_wr_n <= 1'b1;
        @(posedge core_clk);
        // Released bus shows no stale value
        config_addr_bus <= ~a;
        config_data_bus <= ~d;
    endtask
endmodule
`default_nettype wire

// File: sim/dfcc_config_control_chk.sv
// Checker for the configuration control block.
// Assumes binding onto the top module's ports.
`default_nettype none
module dfcc_config_control_chk
    import dfcc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Watched inputs
    input wire logic [ADDR_W-1:0] config_addr_bus,
    input wire logic config_wr_n,
    input wire logic block_transfer_strobe,
    input wire logic forward_path_enable_n,
    input wire logic reverse_path_enable_n,
    // Watched outputs
    input wire dfcc_coef_wr_t coef_wr,
    input wire logic coef_wr_toggle,
    input wire dfcc_struct_t struct_cfg,
    input wire dfcc_format_t format_cfg,
    input wire logic [DEC_W:0] tap_delay,
    input wire logic [ROUND_POSITIONS-1:0] round_select,
    input wire logic [NUM_CELLS-1:0] cell_transfer_n,
    input wire logic [NUM_CELLS-1:0] cell_fwd_zero,
    input wire logic [NUM_CELLS-1:0] cell_rev_zero,
    input wire logic [NUM_CELLS-1:0] cell_alu_subtract,
    input wire logic cell_b_from_b_bus,
    input wire logic shift_enable,
    input wire logic accumulate,
    input wire logic filter_reset,
    input wire logic pipeline_primed
);
    logic [3:0] run_cnt;
    // Cycles since the write-triggered reset ended
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_cnt <= '0;
        end else if (filter_reset) begin
            run_cnt <= '0;
        end else if (run_cnt != 4'hF) begin
            run_cnt <= run_cnt + 4'h1;
        end
    end
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    sequence ctrl_write;
        $rose(config_wr_n) && config_addr_bus[ADDR_W-1:1] == '0;
    endsequence
    sequence coef_write;
        $rose(config_wr_n) && config_addr_bus[ADDR_COEF_BIT];
    endsequence
    a_reset_start: assert property (ctrl_write |-> ##[2:6] filter_reset)
        else $error("control write did not start filter reset");
    a_reset_len: assert property ($rose(filter_reset) |-> filter_reset [*6])
        else $error("filter reset shorter than six cycles");
    a_reset_idle: assert property (filter_reset && $past(filter_reset, 2) |-> !shift_enable && !accumulate)
        else $error("filter enables active during reset");
    a_fill_len: assert property ($fell(filter_reset) |-> !pipeline_primed [*8])
        else $error("pipeline primed too early");
    a_tap_delay: assert property (tap_delay == {1'b0, struct_cfg.dec_factor} + 5'h01)
        else $error("tap delay not factor plus one");
    a_round_sel: assert property (round_select == ((format_cfg.round_enable && format_cfg.round_pos < 4'hC) ?
        12'h001 << format_cfg.round_pos : 12'h000))
        else $error("round select mismatch");
    a_xfer_delay: assert property (run_cnt > 4'h7 |-> cell_transfer_n[0] ==
        ($past(struct_cfg.even_taps[0]) ? $past(block_transfer_strobe, 4) : $past(block_transfer_strobe, 5)))
        else $error("transfer strobe delay wrong");
    a_xfer_delay_b: assert property (run_cnt > 4'h7 |-> cell_transfer_n[1] ==
        ($past(struct_cfg.even_taps[1]) ? $past(block_transfer_strobe, 4) : $past(block_transfer_strobe, 5)))
        else $error("cell B transfer strobe delay wrong");
    a_rev_zero: assert property (run_cnt > 4'h2 |-> cell_rev_zero[1] == $past(reverse_path_enable_n, 2))
        else $error("reverse zero not registered pin");
    a_alu_sub: assert property (cell_alu_subtract == {2{$past(struct_cfg.odd_symmetry)}})
        else $error("subtract not following symmetry");
    a_b_source: assert property (cell_b_from_b_bus == $past(struct_cfg.dual_mode && struct_cfg.b_from_b_bus))
        else $error("cell B source wrong");
    a_fwd_zero: assert property (run_cnt > 4'h2 |-> cell_fwd_zero[0] == $past(forward_path_enable_n, 2))
        else $error("forward zero not registered pin");
    a_coef_wr: assert property (coef_write |-> coef_wr_toggle != $past(coef_wr_toggle) &&
        coef_wr.addr == config_addr_bus[7:0])
        else $error("coefficient write not handed off");
    a_coef_kept: assert property (filter_reset |-> $stable(coef_wr) && $stable(coef_wr_toggle))
        else $error("coefficient changed during reset");
endmodule
bind dfcc_config_control dfcc_config_control_chk u_chk (.core_clk, .rst_n, .config_addr_bus, .config_wr_n,
    .block_transfer_strobe, .forward_path_enable_n, .reverse_path_enable_n, .coef_wr, .coef_wr_toggle,
    .struct_cfg, .format_cfg, .tap_delay, .round_select, .cell_transfer_n, .cell_fwd_zero, .cell_rev_zero,
    .cell_alu_subtract, .cell_b_from_b_bus, .shift_enable, .accumulate, .filter_reset, .pipeline_primed);
`default_nettype wire

// File: sim/dfcc_config_control_tb.sv
// Bench for the configuration control block.
// Assumes the host model owns the configuration port.
`default_nettype none
module dfcc_config_control_tb
    import dfcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [DATA_W-1:0] config_data_bus;
    logic [ADDR_W-1:0] config_addr_bus;
    logic config_wr_n;
    logic block_transfer_strobe = 1'b1;
    logic forward_path_enable_n = 1'b0;
    logic reverse_path_enable_n = 1'b0;
    logic sample_shift_enable_n = 1'b0;
    logic accumulate_enable = 1'b0;
    logic [1:0] output_combine_select = 2'h0;
    dfcc_coef_wr_t coef_wr;
    dfcc_struct_t struct_cfg;
    dfcc_format_t format_cfg;
    logic [DEC_W:0] tap_delay;
    logic [ROUND_POSITIONS-1:0] round_select;
    logic [1:0] cell_transfer_n, combine_select;
    logic coef_wr_toggle, shift_enable, accumulate, filter_reset, pipeline_primed;
    int err_count = 0;
    int tests_run = 0;
    always #2.5 core_clk = ~core_clk;
    dfcc_host_model host (.core_clk, .config_data_bus, .config_addr_bus, .config_wr_n);
    dfcc_config_control DUT (.core_clk, .rst_n, .config_data_bus, .config_addr_bus, .config_wr_n,
        .block_transfer_strobe, .forward_path_enable_n, .reverse_path_enable_n, .sample_shift_enable_n,
        .accumulate_enable, .output_combine_select, .coef_wr, .coef_wr_toggle, .struct_cfg, .format_cfg,
        .tap_delay, .round_select, .cell_transfer_n, .cell_alu_subtract(), .cell_fwd_zero(), .cell_rev_zero(),
        .cell_b_from_b_bus(), .shift_enable, .accumulate, .combine_select, .filter_reset, .pipeline_primed);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Waits out a write-triggered reset and the refill
    task automatic settle(output int hi);
        int n = 0;
        hi = 0;
        while (!filter_reset && n < 20) begin
            @(posedge core_clk);
            #1 n++;
        end
        while (filter_reset && hi < 40) begin
            @(posedge core_clk);
            #1 hi++;
        end
        for (n = 0; n < 40 && !pipeline_primed; n++) begin
            @(posedge core_clk);
            #1;
        end
        #1 chk(pipeline_primed, 1'b1);
    endtask
    task automatic wr_ctrl(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int hi;
        host.write(a, d);
        settle(hi);
        chk(hi, RESET_CYCLES);
    endtask
    task automatic t_reset;
        chk({struct_cfg, format_cfg}, '0);
        chk({filter_reset, pipeline_primed, cell_transfer_n}, 4'h7);
        $display("t_reset done");
    endtask
    task automatic t_word0;
        logic [DATA_W-1:0] tbl[4] = '{10'h0B5, 10'h14A, 10'h1D0, 10'h00F};
        foreach (tbl[i]) begin
            wr_ctrl(ADDR_STRUCT_CTRL, tbl[i]);
            chk(struct_cfg, {tbl[i][3:0], tbl[i][4], tbl[i][5], tbl[i][7:6], tbl[i][8]});
            chk(tap_delay, {1'b0, tbl[i][3:0]} + 5'h01);
        end
        $display("t_word0 done");
    endtask
    task automatic t_word1;
        logic [DATA_W-1:0] tbl[4] = '{10'h161, 10'h000, 10'h3E5, 10'h01A};
        logic [DATA_W-1:0] d;
        foreach (tbl[i]) begin
            d = tbl[i];
            wr_ctrl(ADDR_FORMAT_CTRL, d);
            chk(format_cfg, {d[2], d[0], d[3], d[1], ~d[4], d[8:5], ~d[9]});
            chk(round_select, (!d[9] && d[8:5] < 4'hC) ? 12'h001 << d[8:5] : 12'h000);
        end
        $display("t_word1 done");
    endtask
    task automatic t_coef;
        logic tog = coef_wr_toggle;
        dfcc_struct_t s = struct_cfg;
        host.write(9'h125, 10'h2C3);
        repeat (8) @(posedge core_clk);
        #1 chk({coef_wr, coef_wr_toggle}, {8'h25, 10'h2C3, ~tog});
        chk({filter_reset, struct_cfg}, {1'b0, s});
        wr_ctrl(ADDR_STRUCT_CTRL, 10'h0B5);
        chk(coef_wr, {8'h25, 10'h2C3});
        $display("t_coef done");
    endtask
    task automatic t_rewrite;
        int hi;
        host.write(ADDR_STRUCT_CTRL, 10'h0A3);
        // Decimated symmetric set run with reversal off
        host.write(ADDR_FORMAT_CTRL, 10'h0F0);
        settle(hi);
        chk({struct_cfg, format_cfg}, {4'h3, 1'b0, 1'b1, 2'b10, 1'b0, 2'b00, 2'b00, 1'b0, 4'h7, 1'b1});
        $display("t_rewrite done");
    endtask
    task automatic t_pins;
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            output_combine_select <= i[1:0];
            accumulate_enable <= i[0];
            block_transfer_strobe <= i[0];
            reverse_path_enable_n <= i[0];
            sample_shift_enable_n <= i[1];
            forward_path_enable_n <= i[1];
            repeat (3) @(posedge core_clk);
            #1 chk({combine_select, accumulate, shift_enable}, {i[1:0], i[0], ~i[1]});
        end
        $display("t_pins done");
    endtask
    task final_report;
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1 t_reset();
        t_word0();
        t_word1();
        t_coef();
        t_rewrite();
        t_pins();
        final_report();
    end
    initial begin
        repeat (6000) @(posedge core_clk);
        err_count++;
        final_report();
    end
endmodule
`default_nettype wire
